// *** core/rag_pkg.sv ***
// Shared constants for the receive input gain control loop.
package rag_pkg;
  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NCH    = 4;   // Number of converter inputs.
  localparam int SMP_W  = 16;  // Sample width.
  localparam int ACC_W  = 32;  // Loop accumulator width.
  localparam int ERR_AW = 7;   // Error table address width (128 entries).
  localparam int ERR_W  = 8;   // Error table data width.
  localparam int MAP_AW = 6;   // Attenuator and gain table address width.
  localparam int DVGA_W = 6;   // Attenuator pin code width.
  localparam int GAIN_W = 16;  // Gain table data width.
  localparam int SYNC_N = 8;   // Number of sync sources.
  localparam int SEL_W  = 3;   // Sync selector width.
  localparam int DLY_N  = 32;  // Gain address delay depth (0 to 31).
  localparam int WIN_W  = 16;  // Window timer and count width.
  localparam int UPD_W  = 8;   // Update limit width.
  localparam int SHF_W  = 5;   // Shift and delay setting width.
  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int SD_MSB   = 23;  // Squared sample bits seen by signal loss.
  localparam int SD_LSB   = 8;
  localparam int CLIP_MSB = 31;  // Squared sample bits seen by clip detect.
  localparam int CLIP_LSB = 16;
  // ==========================================================================
  // Table select codes and reset values
  // ==========================================================================
  localparam logic [1:0]        TBL_ERR    = 2'h0;
  localparam logic [1:0]        TBL_DVGA   = 2'h1;
  localparam logic [1:0]        TBL_GAIN   = 2'h2;
  localparam logic [ACC_W-1:0]  ACC_RST    = 32'h0000_0000;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h0100;
  localparam logic [DVGA_W-1:0] DVGA_RST   = 6'h00;
  localparam logic [UPD_W-1:0]  UPD_FREE   = 8'h00;
  localparam int                PIN_FF     = 3;  // Flops on each sync pin.
  // Update limiter states.
  typedef enum logic [0:0] {LIM_RUN, LIM_DONE} rag_lim_e;
endpackage

// *** core/rag_det_if.sv ***
// Carrier between the loop and one windowed sample-count detector.
`timescale 1ns/1ns
`default_nettype none
interface rag_det_if;
  logic                    qualify;  // Sample meets the threshold.
  logic                    restart;  // Start a fresh window.
  logic [rag_pkg::WIN_W-1:0] window; // Window length minus one.
  logic [rag_pkg::WIN_W-1:0] need;   // Count to reach or exceed.
  logic                    hit;      // One cycle when the count is met.
  logic                    met;      // Count met in current or last window.
  modport det (input qualify, restart, window, need, output hit, met);
  modport user (output qualify, restart, window, need, input hit, met);
endinterface
`default_nettype wire

// *** core/rag_window_det.sv ***
// Counts qualifying samples inside a repeating window.
`timescale 1ns/1ns
`default_nettype none
module rag_window_det #(
  parameter bit EXCEED = 1'b1  // One: count must exceed need; zero: reach it.
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Detector link.
  rag_det_if.det   d
);
  logic [rag_pkg::WIN_W:0]   cnt_reg;    // Qualifying samples this window.
  logic [rag_pkg::WIN_W-1:0] tmr_reg;    // Window timer.
  logic                      fired_reg;  // Already fired this window.
  logic [rag_pkg::WIN_W:0]   cnt_now;
  logic                      fire;
  logic                      wend;

  assign cnt_now = cnt_reg + {{rag_pkg::WIN_W{1'b0}}, d.qualify};
  assign fire    = EXCEED ? (cnt_now > {1'b0, d.need}) : (cnt_now >= {1'b0, d.need});
  assign wend    = (tmr_reg == d.window);

  // ==========================================================================
  // Window timer and counter
  // ==========================================================================
  // Counts restart at each window end so old samples never carry over.
  always_ff @(posedge mclk) begin
    if (rst || d.restart) begin
      cnt_reg <= '0;
      tmr_reg <= '0;
    end else if (wend) begin
      cnt_reg <= '0;
      tmr_reg <= '0;
    end else begin
      cnt_reg <= cnt_now;
      tmr_reg <= tmr_reg + 16'h0001;
    end
  end

  // Hit pulses once per window; met sets on fire and at window end keeps the finished window's result.
  always_ff @(posedge mclk) begin
    if (rst || d.restart) begin
      fired_reg <= 1'b0;
      d.hit     <= 1'b0;
      d.met     <= 1'b0;
    end else begin
      d.hit     <= fire && !fired_reg;
      fired_reg <= wend ? 1'b0 : (fired_reg || fire);
      if (fire) begin
        d.met <= 1'b1;
      end else if (wend) begin
        d.met <= fired_reg;
      end
    end
  end
endmodule
`default_nettype wire

// *** core/rag_loop.sv ***
// Four-input receive gain control loop with map tables and detectors.
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: Limit updates per sync; zero means unlimited.
// R2: Software hold bit freezes the loop.
// R3: Software clear bit zeroes the accumulator.
// R4: Three-bit selector picks the clearing sync.
// R5: Signal loss freezes only when enabled.
// R6: Loss threshold compares squared bits 23:8.
// R7: Loss when low count reaches count in window.
// R8: Clip starts when high count exceeds count.
// R9: Clip ends when low count exceeds count.
// R10: Clip error added MSB-aligned while clipping.
// R11: Per-input 128 by 8 error table.
// R12: Per-input 64 by 6 attenuator table.
// R13: Per-input 64 by 16 gain table.
// R14: Gain address delayed 0 to 31 cycles.
// R15: Error shifted up before accumulating.
// R16: Two bits pair inputs into complex mode.
// R17: Accumulator readable by software.
// R18: Per-input bits three-state attenuator pins.
// R19: Readback mode exposes tables, stops path.
// R20: Freeze holds accumulator constant.
// R21: Upper six accumulator bits address tables.
// R22: Table error added once per update.
// R23: Clear zeroes all bits next clock.
module rag_loop #(
  parameter int NCH = rag_pkg::NCH  // Number of inputs handled.
) (
  // Clock and reset.
  input  wire logic                                mclk,
  input  wire logic                                rst,
  // Samples on the clock domain, and asynchronous sync pins.
  input  wire logic [NCH-1:0][rag_pkg::SMP_W-1:0]  rx_sample,
  input  wire logic [rag_pkg::SYNC_N-1:0]          sync_pin,
  // Measurement update pulse and error table index per input.
  input  wire logic [NCH-1:0]                      meas_update,
  input  wire logic [NCH-1:0][rag_pkg::ERR_AW-1:0] meas_index,
  // Loop control per input.
  input  wire logic [NCH-1:0]                      sw_hold,
  input  wire logic [NCH-1:0]                      sw_clear,
  input  wire logic [NCH-1:0][rag_pkg::SEL_W-1:0]  clear_sel,
  input  wire logic [NCH-1:0][rag_pkg::SEL_W-1:0]  freeze_sel,
  input  wire logic [NCH-1:0][rag_pkg::UPD_W-1:0]  update_limit,
  input  wire logic [NCH-1:0][rag_pkg::SHF_W-1:0]  err_shift,
  input  wire logic [NCH-1:0][rag_pkg::SHF_W-1:0]  delay_adj,
  input  wire logic [NCH-1:0][15:0]                clip_error,
  // Signal loss detector settings.
  input  wire logic [NCH-1:0]                      signal_loss_hold_enable,
  input  wire logic [NCH-1:0][15:0]                signal_loss_threshold,
  input  wire logic [NCH-1:0][15:0]                signal_loss_sample_count,
  input  wire logic [NCH-1:0][15:0]                signal_loss_window,
  // Clip detector settings.
  input  wire logic [NCH-1:0][15:0]                overload_enter_threshold,
  input  wire logic [NCH-1:0][15:0]                overload_exit_threshold,
  input  wire logic [NCH-1:0][7:0]                 overload_enter_count,
  input  wire logic [NCH-1:0][7:0]                 overload_exit_count,
  input  wire logic [NCH-1:0][15:0]                overload_enter_window,
  input  wire logic [NCH-1:0][15:0]                overload_exit_window,
  // Pairing and pin control.
  input  wire logic                                pair_first_inputs_iq,
  input  wire logic                                pair_last_inputs_iq,
  input  wire logic [NCH-1:0]                      dvga_tristate,
  // Map table access port.
  input  wire logic                                map_write,
  input  wire logic [1:0]                          map_table,
  input  wire logic [1:0]                          map_chan,
  input  wire logic [rag_pkg::ERR_AW-1:0]          map_addr,
  input  wire logic [15:0]                         map_wdata,
  input  wire logic                                map_readback_mode,
  output logic      [15:0]                         map_rdata,
  // Attenuator pins, gain and status.
  output logic      [NCH-1:0][rag_pkg::DVGA_W-1:0] dvga_out,
  output logic      [NCH-1:0]                      dvga_oe,
  output logic      [NCH-1:0][rag_pkg::GAIN_W-1:0] gain_out,
  output logic      [NCH-1:0][rag_pkg::ACC_W-1:0]  loop_accumulator_value,
  output logic      [NCH-1:0]                      signal_loss_flag,
  output logic      [NCH-1:0]                      overload_flag
);
  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // True when a table write targets the given input and table.
  function automatic logic tbl_hit(input logic [1:0] tbl, input logic [1:0] ch,
                                   input logic [1:0] want, input int idx);
    tbl_hit = (tbl == want) && (ch == idx[1:0]);
  endfunction

  // ==========================================================================
  // Sync pin conditioning
  // ==========================================================================
  logic [rag_pkg::SYNC_N-1:0] s1_reg;    // First flop, read only by s2.
  logic [rag_pkg::SYNC_N-1:0] s2_reg;
  logic [rag_pkg::SYNC_N-1:0] s3_reg;
  logic [rag_pkg::SYNC_N-1:0] sync_lvl;  // Accepted level.
  logic [rag_pkg::SYNC_N-1:0] sync_evt;  // One cycle on each rising level.

  // Three flops; a level is accepted once the last two agree.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      sync_lvl <= '0;
      sync_evt <= '0;
    end else begin
      s1_reg   <= sync_pin;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      for (int k = 0; k < rag_pkg::SYNC_N; k++) begin
        if (s2_reg[k] == s3_reg[k]) begin
          sync_lvl[k] <= s3_reg[k];
        end
        sync_evt[k] <= (s2_reg[k] == s3_reg[k]) && s3_reg[k] && !sync_lvl[k];
      end
    end
  end

  logic [NCH-1:0][15:0] rd_all;  // Readback value offered by each input.

  // ==========================================================================
  // Per-input loop
  // ==========================================================================
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : ch_g
      localparam int ODD = i | 1;
      localparam int EVN = i & ~1;

      logic [rag_pkg::ERR_W-1:0]  err_map  [0:127];  // Power to error. [R11]
      logic [rag_pkg::DVGA_W-1:0] dvga_map [0:63];   // Code to pins. [R12]
      logic [rag_pkg::GAIN_W-1:0] gain_map [0:63];   // 16'h0100 is unity. [R13]
      logic [rag_pkg::MAP_AW-1:0] dly_reg  [0:rag_pkg::DLY_N-1];
      logic [rag_pkg::ACC_W-1:0]  acc_reg;           // Loop accumulator.
      logic [31:0]                sq_reg;            // Squared sample.
      logic [rag_pkg::UPD_W-1:0]  upd_reg;           // Updates since sync.
      rag_pkg::rag_lim_e          lim_reg;
      logic                       clip_reg;          // Clip event active.
      logic                       pair;
      logic [31:0]                pow;
      logic                       clip_any;
      logic                       freeze;
      logic                       clear;
      logic [rag_pkg::ACC_W-1:0]  err_ext;
      logic [rag_pkg::MAP_AW-1:0] addr;
      logic [rag_pkg::MAP_AW-1:0] gaddr;
      logic signed [31:0]         prod;

      rag_det_if loss_if ();
      rag_det_if hi_if ();
      rag_det_if lo_if ();

      assign pair = (i < 2) ? pair_first_inputs_iq : pair_last_inputs_iq;
      assign prod = $signed(rx_sample[i]) * $signed(rx_sample[i]);
      // Complex mode sums I and Q power on the even input. [R16]
      assign pow  = (pair && i == EVN) ? sq_reg + ch_g[ODD].sq_reg : sq_reg;
      // Clip of the odd input also drives the even loop when paired. [R16]
      assign clip_any = clip_reg || (pair && i == EVN && ch_g[ODD].clip_reg);
      // Software clear or the selected sync event zeroes the loop. [R3] [R4]
      assign clear  = sw_clear[i] || sync_evt[clear_sel[i]];
      // Any freeze source holds the loop. [R2] [R5] [R1] [R19]
      assign freeze = sw_hold[i] || (signal_loss_hold_enable[i] && loss_if.met)
                   || sync_lvl[freeze_sel[i]] || map_readback_mode
                   || (lim_reg == rag_pkg::LIM_DONE && update_limit[i] != rag_pkg::UPD_FREE);
      // Error is sign extended then shifted up. [R15]
      assign err_ext = {{24{err_map[meas_index[i]][7]}}, err_map[meas_index[i]]}
                       << err_shift[i];
      // Upper six bits address both maps; paired odd uses even's loop. [R21]
      assign addr  = (pair && i == ODD) ? ch_g[EVN].acc_reg[31:26] : acc_reg[31:26];
      assign gaddr = (delay_adj[i] == 5'h00) ? addr : dly_reg[delay_adj[i] - 5'h01];

      // Signal loss: squared bits 23:8 under threshold, count reached. [R6] [R7]
      assign loss_if.qualify = pow[rag_pkg::SD_MSB:rag_pkg::SD_LSB]
                               < signal_loss_threshold[i];
      assign loss_if.restart = clear;
      assign loss_if.window  = signal_loss_window[i];
      assign loss_if.need    = signal_loss_sample_count[i];
      // Clip start: samples above high threshold exceed count. [R8]
      assign hi_if.qualify = pow[rag_pkg::CLIP_MSB:rag_pkg::CLIP_LSB]
                             > overload_enter_threshold[i];
      assign hi_if.restart = clip_reg;
      assign hi_if.window  = overload_enter_window[i];
      assign hi_if.need    = {8'h00, overload_enter_count[i]};
      // Clip end: samples below low threshold exceed count. [R9]
      assign lo_if.qualify = pow[rag_pkg::CLIP_MSB:rag_pkg::CLIP_LSB]
                             < overload_exit_threshold[i];
      assign lo_if.restart = !clip_reg;
      assign lo_if.window  = overload_exit_window[i];
      assign lo_if.need    = {8'h00, overload_exit_count[i]};

      rag_window_det #(.EXCEED(1'b0)) loss_u (.mclk(mclk), .rst(rst), .d(loss_if));
      rag_window_det #(.EXCEED(1'b1)) hi_u (.mclk(mclk), .rst(rst), .d(hi_if));
      rag_window_det #(.EXCEED(1'b1)) lo_u (.mclk(mclk), .rst(rst), .d(lo_if));

      // Table writes from the access port; no reset, software loads them.
      always_ff @(posedge mclk) begin
        if (map_write && tbl_hit(map_table, map_chan, rag_pkg::TBL_ERR, i)) begin
          err_map[map_addr] <= map_wdata[7:0];                         // [R11]
        end
        if (map_write && tbl_hit(map_table, map_chan, rag_pkg::TBL_DVGA, i)) begin
          dvga_map[map_addr[5:0]] <= map_wdata[5:0];                   // [R12]
        end
        if (map_write && tbl_hit(map_table, map_chan, rag_pkg::TBL_GAIN, i)) begin
          gain_map[map_addr[5:0]] <= map_wdata;                        // [R13]
        end
      end

      // Squaring stage; held while the path is stopped for readback.
      always_ff @(posedge mclk) begin
        if (rst) begin
          sq_reg <= '0;
        end else if (!map_readback_mode) begin
          sq_reg <= $unsigned(prod);
        end
      end

      // Clip event state toggled by the two detectors.
      always_ff @(posedge mclk) begin
        if (rst || clear) begin
          clip_reg <= 1'b0;
        end else if (!clip_reg && hi_if.hit) begin
          clip_reg <= 1'b1;                                             // [R8]
        end else if (clip_reg && lo_if.hit) begin
          clip_reg <= 1'b0;                                             // [R9]
        end
      end

      // Loop accumulator: clear wins, then freeze, then clip, then update.
      always_ff @(posedge mclk) begin
        if (rst) begin
          acc_reg <= rag_pkg::ACC_RST;
        end else if (clear) begin
          acc_reg <= rag_pkg::ACC_RST;                                  // [R23]
        end else if (freeze) begin
          acc_reg <= acc_reg;                                           // [R20]
        end else if (clip_any) begin
          acc_reg <= acc_reg + {clip_error[i], 16'h0000};               // [R10]
        end else if (meas_update[i]) begin
          acc_reg <= acc_reg + err_ext;                                 // [R22]
        end
      end

      // Update limiter: software clear or the selected clearing sync event restarts the count of updates.
      always_ff @(posedge mclk) begin
        if (rst || clear) begin
          upd_reg <= '0;
          lim_reg <= rag_pkg::LIM_RUN;
        end else begin
          case (lim_reg)
            rag_pkg::LIM_RUN: begin
              if (!freeze && !clip_any && meas_update[i]
                  && update_limit[i] != rag_pkg::UPD_FREE) begin
                upd_reg <= upd_reg + 8'h01;
                if (upd_reg + 8'h01 == update_limit[i]) begin
                  lim_reg <= rag_pkg::LIM_DONE;                         // [R1]
                end
              end
            end
            rag_pkg::LIM_DONE: lim_reg <= rag_pkg::LIM_DONE;
            default:           lim_reg <= rag_pkg::LIM_RUN;
          endcase
        end
      end

      // Gain address history aligns gain steps with attenuator steps.
      always_ff @(posedge mclk) begin
        if (rst) begin
          for (int k = 0; k < rag_pkg::DLY_N; k++) begin
            dly_reg[k] <= '0;
          end
        end else if (!map_readback_mode) begin
          dly_reg[0] <= addr;                                           // [R14]
          for (int k = 1; k < rag_pkg::DLY_N; k++) begin
            dly_reg[k] <= dly_reg[k-1];
          end
        end
      end

      // Pin and gain outputs; both hold while readback stops the path.
      always_ff @(posedge mclk) begin
        if (rst) begin
          dvga_out[i] <= rag_pkg::DVGA_RST;
          gain_out[i] <= rag_pkg::GAIN_UNITY;
          dvga_oe[i]  <= 1'b0;
        end else begin
          dvga_oe[i] <= !dvga_tristate[i];                              // [R18]
          if (!map_readback_mode) begin
            dvga_out[i] <= dvga_map[addr];                              // [R12]
            gain_out[i] <= gain_map[gaddr];                             // [R14]
          end
        end
      end

      // Status copies and readback candidates.
      always_ff @(posedge mclk) begin
        if (rst) begin
          loop_accumulator_value[i] <= '0;
          signal_loss_flag[i]       <= 1'b0;
          overload_flag[i]          <= 1'b0;
        end else begin
          loop_accumulator_value[i] <= acc_reg;                         // [R17]
          signal_loss_flag[i]       <= loss_if.met;
          overload_flag[i]          <= clip_any;
        end
      end

      assign rd_all[i] = (map_table == rag_pkg::TBL_ERR)  ? {8'h00, err_map[map_addr]} :
                         (map_table == rag_pkg::TBL_DVGA) ? {10'h000, dvga_map[map_addr[5:0]]} :
                         (map_table == rag_pkg::TBL_GAIN) ? gain_map[map_addr[5:0]] : 16'h0000;
    end
  endgenerate

  // ==========================================================================
  // Table readback
  // ==========================================================================
  // Only meaningful in readback mode; otherwise it reads zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      map_rdata <= 16'h0000;
    end else if (map_readback_mode) begin
      map_rdata <= rd_all[map_chan];                                    // [R19]
    end else begin
      map_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// *** tb/rag_loop_monitor.sv ***
// Port-level property checker for the receive gain loop.
`timescale 1ns/1ns
`default_nettype none
module rag_loop_monitor #(parameter int NCH = 4) (
  // Clock, reset, loop controls, pin enable and status flags.
  input wire logic                  mclk, rst, map_readback_mode,
  input wire logic [7:0]            sync_pin,
  input wire logic [NCH-1:0]        sw_clear, sw_hold, dvga_tristate, dvga_oe,
  input wire logic [NCH-1:0]        signal_loss_hold_enable, signal_loss_flag, overload_flag,
  input wire logic [NCH-1:0][2:0]   clear_sel,
  // Observed results.
  input wire logic [15:0]           map_rdata,
  input wire logic [NCH-1:0][5:0]   dvga_out,
  input wire logic [NCH-1:0][31:0]  loop_accumulator_value
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [31:0] acc0;  // Channel zero accumulator copy.
  assign acc0 = loop_accumulator_value[0];
  clear_zero_a: assert property (sw_clear[0] |=> ##1 acc0 == '0)
    else $error("accumulator not zero after clear");
  hold_freeze_a: assert property (sw_hold[0] && !sw_clear[0] |=> $stable(acc0))
    else $error("accumulator moved while held");
  sync_clear_a: assert property ($rose(sync_pin[clear_sel[0]]) && $stable(clear_sel[0])
    |-> ##[3:8] acc0 == '0) else $error("sync did not clear accumulator");
  loss_freeze_a: assert property ((signal_loss_flag[0] && signal_loss_hold_enable[0]
    && !sw_clear[0])[*2] |=> $stable(acc0)) else $error("loop ran during signal loss");
  oe_follow_a: assert property (!map_readback_mode |=> dvga_oe == ~$past(dvga_tristate))
    else $error("pin enable wrong");
  rdata_idle_a: assert property (!map_readback_mode |=> map_rdata == '0)
    else $error("read data outside readback");
  rb_hold_a: assert property (map_readback_mode && !sw_clear[0] |=> $stable(acc0))
    else $error("loop ran during readback");
  rb_pins_a: assert property (map_readback_mode[*3] |=> $stable(dvga_out))
    else $error("pins moved during readback");
  cover property (overload_flag[0]);
  cover property (signal_loss_flag[0]);
  cover property (map_readback_mode ##1 map_rdata != '0);
endmodule
`default_nettype wire

// *** tb/rag_dvga_model.sv ***
// Behavioural attenuator watching one set of code pins.
`timescale 1ns/1ns
`default_nettype none
module rag_dvga_model (
  input wire logic        mclk,
  input wire logic [5:0]  code,
  input wire logic        oe,
  output logic     [5:0]  pin
);
  logic [5:0] last = '0;  // Last code seen while driven.
  always @(posedge mclk) if (oe) last <= code;
  // Released pins float, so show the inverse of the last code; stale data never matches.
  assign pin = oe ? code : ~last;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the gain loop, channel zero in depth.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk = 0, rst = 1, map_write = 0, map_readback_mode = 0;
  logic pair_first_inputs_iq = 0, pair_last_inputs_iq = 0;
  logic [7:0] sync_pin = '0;
  logic [3:0] meas_update = '0, sw_hold = '0, sw_clear = '0, dvga_tristate = '0;
  logic [3:0] signal_loss_hold_enable = '0, dvga_oe, signal_loss_flag, overload_flag;
  logic [3:0][2:0] clear_sel = '0, freeze_sel = '0;
  logic [3:0][4:0] err_shift = '0, delay_adj = '0;
  logic [3:0][6:0] meas_index = '0;
  logic [3:0][7:0] update_limit = '0, overload_enter_count = '0, overload_exit_count = '0;
  logic [3:0][15:0] rx_sample = '0, clip_error = '0, signal_loss_threshold = '0;
  logic [3:0][15:0] signal_loss_sample_count = '0, signal_loss_window = '0, gain_out;
  logic [3:0][15:0] overload_enter_threshold = '1, overload_exit_threshold = '0;
  logic [3:0][15:0] overload_enter_window = '0, overload_exit_window = '0;
  logic [1:0] map_table = '0, map_chan = '0;
  logic [6:0] map_addr = '0, idx;
  logic [15:0] map_wdata = '0, map_rdata;
  logic [3:0][5:0] dvga_out;
  logic [3:0][31:0] loop_accumulator_value;
  logic [5:0] pin0, pexp;
  logic [7:0] err_tbl [128];
  logic [31:0] exp_acc, tmp;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  rag_loop i_rag_loop (.*);
  rag_dvga_model i_rag_dvga_model (.mclk, .code(dvga_out[0]), .oe(dvga_oe[0]), .pin(pin0));
  initial forever #25 mclk = ~mclk;
  // Other inputs see noise all the time; it must never disturb channel zero.
  always @(negedge mclk) for (int c = 1; c < 4; c++) rx_sample[c] <= 16'($urandom);
  always @(posedge mclk) if (++cyc == 6000) begin
    miscompares++;
    summarize();
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_v(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n); repeat (n) @(negedge mclk); endtask
  // Table write; the caller drops the strobe after a burst.
  task automatic wr(input logic [1:0] t, input logic [6:0] a, input logic [15:0] d);
    map_write = 1; map_table = t; map_addr = a; map_wdata = d;
    tick(1);
  endtask
  // One measurement update, then wait until the pins have followed.
  task automatic pulse(input logic [6:0] i);
    meas_update[0] = 1; meas_index[0] = i;
    tick(1);
    meas_update[0] = 0;
    tick(3);
  endtask
  function automatic logic [31:0] step(input logic [7:0] e, input logic [4:0] s);
    return 32'(signed'(e)) << s;
  endfunction
  initial begin
    void'($urandom(24432));
    tick(10);
    rst = 0;
    for (int i = 0; i < 128; i++) begin
      err_tbl[i] = 8'($urandom) | 8'h01;
      wr(2'h0, 7'(i), {8'h00, err_tbl[i]});
    end
    for (int c = 0; c < 4; c++) begin
      map_chan = 2'(c);
      for (int i = 0; i < 64; i++) wr(2'h1, 7'(i), 16'(i ^ 'h2a));
    end
    map_chan = 2'h0;
    wr(2'h2, 7'h00, 16'h0100);
    wr(2'h2, 7'h3f, 16'hbeef);
    map_write = 0;
    exp_acc = '0;
    for (int k = 0; k < 8; k++) begin
      idx = 7'($urandom); err_shift[0] = 5'($urandom_range(20)); rx_sample[0] = 16'($urandom);
      exp_acc += step(err_tbl[idx], err_shift[0]);
      pulse(idx);
      cmp_v(loop_accumulator_value[0], exp_acc);
      cmp_v(pin0, exp_acc[31:26] ^ 6'h2a);
    end
    sw_hold[0] = 1;
    pulse(idx);
    cmp_v(loop_accumulator_value[0], exp_acc);
    sw_hold[0] = 0; exp_acc += step(err_tbl[idx], err_shift[0]);
    pulse(idx);
    cmp_v(loop_accumulator_value[0], exp_acc);
    pair_first_inputs_iq = 1; tick(4);
    cmp_v(dvga_out[1], exp_acc[31:26] ^ 6'h2a);
    pair_first_inputs_iq = 0;
    dvga_tristate[0] = 1; pexp = ~(exp_acc[31:26] ^ 6'h2a); tick(2);
    cmp_v(dvga_oe[0], 0);
    cmp_v(pin0, pexp);
    dvga_tristate[0] = 0; sw_clear[0] = 1; tick(1);
    sw_clear[0] = 0; tick(2);
    cmp_v(loop_accumulator_value[0], 0);
    tick(4);
    cmp_v(gain_out[0], 16'h0100);
    update_limit[0] = 8'h02; clear_sel[0] = 3'h3; exp_acc = '0; pulse(7'h06); tick(1);
    sync_pin[3] = 1; tick(3);
    sync_pin[3] = 0; tick(8);
    for (int k = 0; k < 4; k++) begin
      if (k < 2) exp_acc += step(err_tbl[5], err_shift[0]);
      pulse(7'h05);
    end
    cmp_v(loop_accumulator_value[0], exp_acc);
    update_limit[0] = '0; map_readback_mode = 1; map_table = 2'h2; map_addr = 7'h3f; tick(2);
    cmp_v(map_rdata, 16'hbeef);
    map_table = 2'h1; map_addr = 7'h07; tick(2);
    cmp_v(map_rdata, 6'h07 ^ 6'h2a);
    map_readback_mode = 0; rx_sample[0] = 16'h0010; signal_loss_threshold[0] = 16'h0001;
    signal_loss_sample_count[0] = 16'h0004; signal_loss_window[0] = 16'h0007;
    signal_loss_hold_enable[0] = 1; tick(20);
    cmp_v(signal_loss_flag[0], 0);
    rx_sample[0] = 16'h000f; tick(20);
    cmp_v(signal_loss_flag[0], 1);
    pulse(7'h05);
    cmp_v(loop_accumulator_value[0], exp_acc);
    signal_loss_hold_enable[0] = 0; exp_acc += step(err_tbl[5], err_shift[0]);
    pulse(7'h05);
    cmp_v(loop_accumulator_value[0], exp_acc);
    clip_error[0] = 16'h0003; overload_enter_count[0] = 8'h02; overload_enter_window[0] = 16'h0007;
    rx_sample[0] = 16'h7fff; overload_enter_threshold[0] = '0; tick(12);
    cmp_v(overload_flag[0], 1);
    tmp = loop_accumulator_value[0]; tick(1);
    cmp_v(loop_accumulator_value[0] - tmp, 32'h0003_0000);
    overload_exit_threshold[0] = '1; overload_exit_window[0] = 16'h0007; rx_sample[0] = '0;
    tick(12);
    cmp_v(overload_flag[0], 0);
    summarize();
  end
endmodule
bind rag_loop rag_loop_monitor #(.NCH(NCH)) i_rag_loop_monitor (.*);
`default_nettype wire
